//--- core/tpw_pkg.sv
// Purpose: Shared constants and types for the timer channel waveform block
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes: Offsets and field positions are local to this block
package tpw_pkg;

  localparam int CNT_W = 16;
  localparam int NUM_CH = 2;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_EVENT = 8'h04;
  localparam logic [7:0] OFF_CHCFG = 8'h08;
  localparam logic [7:0] OFF_PERIOD = 8'h0c;
  localparam logic [7:0] OFF_COUNT = 8'h10;
  localparam logic [7:0] OFF_CMP0 = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h1c;

  // ==========================================================================
  // Control and event register fields
  localparam int CTRL_EN = 0;
  localparam int CTRL_SINGLE = 1;
  localparam int CTRL_DIR = 2;
  localparam int CTRL_ALIGN_LO = 3;
  localparam int CTRL_PPRE = 5;
  localparam int CTRL_TRIG_START = 6;
  localparam int EVT_FORCE_UPD = 0;

  // Per-channel config byte: mode[2:0], preload, fast, clear, polarity, enable
  localparam int CH_STRIDE = 8;
  localparam int CH_PRE = 3;
  localparam int CH_FAST = 4;
  localparam int CH_CLR = 5;
  localparam int CH_POL = 6;
  localparam int CH_OE = 7;

  localparam logic [2:0] MODE_FROZEN = 3'h0;
  localparam logic [2:0] MODE_SET = 3'h1;
  localparam logic [2:0] MODE_CLEAR = 3'h2;
  localparam logic [2:0] MODE_TOGGLE = 3'h3;
  localparam logic [2:0] MODE_FORCE_LOW = 3'h4;
  localparam logic [2:0] MODE_FORCE_HIGH = 3'h5;
  localparam logic [2:0] MODE_PWM1 = 3'h6;
  localparam logic [2:0] MODE_PWM2 = 3'h7;

  localparam logic [1:0] ALIGN_EDGE = 2'h0;
  localparam logic [1:0] ALIGN_CENTER_DOWN = 2'h1;
  localparam logic [1:0] ALIGN_CENTER_UP = 2'h2;

  // Members run from the top bit down, so they follow the field positions above
  typedef struct packed {
    logic output_enable_bit;
    logic output_polarity_bit;
    logic external_clear_enable;
    logic fast_trigger_enable;
    logic compare_preload_enable;
    logic [2:0] compare_mode_field;
  } tpw_chan_type;

  typedef struct packed {
    logic trigger_start;
    logic period_preload_enable;
    logic [1:0] alignment_select_field;
    logic dir;
    logic single_pulse_bit;
    logic counter_enable_bit;
  } tpw_ctrl_type;

endpackage : tpw_pkg

//--- core/tpw_channel_pwm.sv
// Purpose: Timer counter plus per-channel PWM, one-pulse and external clear
// Assumes: Trigger and external clear pins are asynchronous to ref_clk
// Notes: One counter tick per ref_clk edge; no prescaler
//
// Our own choices: register access over APB and the address map.
`timescale 1ns/10ps

// Operation
// - Mode field 110 selects PWM mode 1, 111 PWM mode 2, per channel.
// - Preloads reach shadows only on update event; software forces one first.
// - Polarity bit picks active level; output drives only when enabled.
// - Reference asserts only on compare result change or frozen-to-PWM switch.
// - Direction low means up-counting; alignment field picks edge or center.
// - PWM1 up-counting: reference high while counter below compare.
// - Up-counting: compare above period holds high, compare zero holds low.
// - PWM1 down-counting: low while counter above compare, else high.
// - Nonzero alignment is center mode; flag on up, down or both.
// - Center mode hardware updates direction, starting from written direction.
// - Counter writes above period keep direction; 0 or period update it.
// - Single-pulse bit stops counter at next update event; the code stops it on overflow only, not on a forced update.
// - Trigger edge in single-pulse operation sets counter enable.
// - Pulse delay equals compare; length equals period minus compare plus one.
// - Fast enable forces reference to match level on trigger in PWM.
// - Clear enable with high external trigger holds reference low until update.
// - External clear acts in compare and PWM modes, not forced modes.
// - At full duty a cleared reference returns at next overflow.
// - Compare and period load directly or via preload per enable bits.
// - Update event leaves output compare modes untouched; tick resolution.
module tpw_channel_pwm #(
  parameter int CNT_W = tpw_pkg::CNT_W,
  parameter int NUM_CH = tpw_pkg::NUM_CH
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic slave_trigger_input,
  input wire logic filtered_external_trigger,
  output logic [NUM_CH-1:0] chan_out,
  output logic [NUM_CH-1:0] compare_flag
);

  // ==========================================================================
  // Pin synchronisers
  // Edge detector resets low, the idle level of the trigger pin, so no false start
  logic [1:0] trig_sync;
  logic [1:0] etr_sync;
  logic trig_prev;
  logic trig_edge;
  logic etr_high;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      trig_sync <= 2'h0;
      etr_sync <= 2'h0;
      trig_prev <= 1'b0;
    end else begin
      trig_sync <= {trig_sync[0], slave_trigger_input};
      etr_sync <= {etr_sync[0], filtered_external_trigger};
      trig_prev <= trig_sync[1];
    end
  end

  assign trig_edge = trig_sync[1] & ~trig_prev;
  assign etr_high = etr_sync[1];

  // ==========================================================================
  // APB decode
  tpw_pkg::tpw_ctrl_type ctrl;
  tpw_pkg::tpw_chan_type [NUM_CH-1:0] chan_cfg;
  logic [CNT_W-1:0] period_pre;
  logic [CNT_W-1:0] period_sh;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] cmp_pre [NUM_CH];
  logic [CNT_W-1:0] cmp_sh [NUM_CH];
  logic wr;
  logic rd;
  logic wr_ctrl;
  logic wr_chcfg;
  logic wr_period;
  logic wr_count;
  logic force_update;
  logic [NUM_CH-1:0] wr_cmp;
  logic addr_ok;

  function automatic logic is_cmp_addr(input logic [7:0] a, input int ch);
    is_cmp_addr = (a == 8'(tpw_pkg::OFF_CMP0 + 4 * ch));
  endfunction : is_cmp_addr

  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign wr_ctrl = wr & (paddr == tpw_pkg::OFF_CTRL);
  assign wr_chcfg = wr & (paddr == tpw_pkg::OFF_CHCFG);
  assign wr_period = wr & (paddr == tpw_pkg::OFF_PERIOD);
  assign wr_count = wr & (paddr == tpw_pkg::OFF_COUNT);
  assign force_update = wr & (paddr == tpw_pkg::OFF_EVENT) & pwdata[tpw_pkg::EVT_FORCE_UPD];

  always_comb begin
    addr_ok = (paddr == tpw_pkg::OFF_CTRL) || (paddr == tpw_pkg::OFF_EVENT)
           || (paddr == tpw_pkg::OFF_CHCFG) || (paddr == tpw_pkg::OFF_PERIOD)
           || (paddr == tpw_pkg::OFF_COUNT) || (paddr == tpw_pkg::OFF_STATUS);
    for (int i = 0; i < NUM_CH; i++) begin
      wr_cmp[i] = wr & is_cmp_addr(paddr, i);
      if (is_cmp_addr(paddr, i)) begin
        addr_ok = 1'b1;
      end
    end
  end

  assign pslverr = psel & penable & ~addr_ok;

  // ==========================================================================
  // Counter core
  logic center;
  logic at_top;
  logic at_bottom;
  logic update_event;
  logic overflow;

  assign center = ctrl.alignment_select_field != tpw_pkg::ALIGN_EDGE;
  assign at_top = count >= period_sh;
  assign at_bottom = count == '0;
  // Wrap point of the running counter, plus the software-forced update
  // Center mode wraps where the direction turns, one tick before each end
  assign overflow = ctrl.counter_enable_bit & (center
                    ? ((~ctrl.dir & (count == period_sh - CNT_W'(1)))
                      | (ctrl.dir & (count == CNT_W'(1))))
                    : (ctrl.dir ? at_bottom : at_top));
  assign update_event = overflow | force_update;

  // Control register, with hardware start/stop and direction
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= '0;
    end else if (wr_ctrl) begin
      // Field by field, so the layout does not hang on the member order
      ctrl.counter_enable_bit <= pwdata[tpw_pkg::CTRL_EN];
      ctrl.single_pulse_bit <= pwdata[tpw_pkg::CTRL_SINGLE];
      ctrl.dir <= pwdata[tpw_pkg::CTRL_DIR];
      ctrl.alignment_select_field <= pwdata[tpw_pkg::CTRL_ALIGN_LO +: 2];
      ctrl.period_preload_enable <= pwdata[tpw_pkg::CTRL_PPRE];
      ctrl.trigger_start <= pwdata[tpw_pkg::CTRL_TRIG_START];
    end else begin
      if (ctrl.single_pulse_bit && overflow) begin
        ctrl.counter_enable_bit <= 1'b0;
      end else if (ctrl.single_pulse_bit && ctrl.trigger_start && trig_edge) begin
        ctrl.counter_enable_bit <= 1'b1;
      end
      if (center && ctrl.counter_enable_bit) begin
        if (!ctrl.dir && count == period_sh - CNT_W'(1)) begin
          ctrl.dir <= 1'b1;
        end else if (ctrl.dir && count == CNT_W'(1)) begin
          ctrl.dir <= 1'b0;
        end
      end
      if (center && wr_count) begin
        if (pwdata[CNT_W-1:0] == '0) begin
          ctrl.dir <= 1'b0;
        end else if (pwdata[CNT_W-1:0] == period_sh) begin
          ctrl.dir <= 1'b1;
        end
      end
    end
  end

  // Counter value
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      count <= '0;
    end else if (wr_count) begin
      count <= pwdata[CNT_W-1:0];
    end else if (force_update) begin
      // Shadow period moves in on this same edge, so start from the pending value
      count <= ctrl.dir && !center ? period_pre : '0;
    end else if (ctrl.counter_enable_bit) begin
      if (!ctrl.dir) begin
        count <= (at_top && !center) ? '0 : count + CNT_W'(1);
      end else begin
        count <= at_bottom ? period_sh : count - CNT_W'(1);
      end
    end
  end

  // Period preload and shadow
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      period_pre <= '1;
      period_sh <= '1;
    end else begin
      if (wr_period) begin
        period_pre <= pwdata[CNT_W-1:0];
      end
      if (wr_period && !ctrl.period_preload_enable) begin
        period_sh <= pwdata[CNT_W-1:0];
      end else if (update_event) begin
        period_sh <= period_pre;
      end
    end
  end

  // Channel configuration
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      chan_cfg <= '0;
    end else if (wr_chcfg) begin
      chan_cfg <= pwdata[NUM_CH*tpw_pkg::CH_STRIDE-1:0];
    end
  end

  // ==========================================================================
  // Channels
  logic [NUM_CH-1:0] ref_sig;
  logic [NUM_CH-1:0] cmp_prev;
  logic [NUM_CH-1:0] cleared;
  logic [NUM_CH-1:0] cmp_res;
  logic [NUM_CH-1:0] pwm;
  logic [NUM_CH-1:0] match;

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    logic [2:0] mode;
    logic [2:0] last_mode;
    logic clr_ok;
    logic active_now;

    assign mode = chan_cfg[c].compare_mode_field;
    assign pwm[c] = mode[2] & mode[1];
    assign match[c] = ctrl.counter_enable_bit & (count == cmp_sh[c]);
    assign clr_ok = chan_cfg[c].external_clear_enable & (mode != tpw_pkg::MODE_FORCE_LOW)
                    & (mode != tpw_pkg::MODE_FORCE_HIGH);

    // PWM1 level: up uses cnt<cmp, down uses cnt<=cmp; cmp 0 up holds low
    always_comb begin
      if (!ctrl.dir) begin
        active_now = count < cmp_sh[c];
      end else begin
        active_now = (count <= cmp_sh[c]) | (cmp_sh[c] > period_sh);
      end
      cmp_res[c] = (mode == tpw_pkg::MODE_PWM2) ? ~active_now : active_now;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
        cmp_pre[c] <= '0;
        cmp_sh[c] <= '0;
      end else begin
        if (wr_cmp[c]) begin
          cmp_pre[c] <= pwdata[CNT_W-1:0];
        end
        if (wr_cmp[c] && !chan_cfg[c].compare_preload_enable) begin
          cmp_sh[c] <= pwdata[CNT_W-1:0];
        end else if (update_event) begin
          cmp_sh[c] <= cmp_pre[c];
        end
      end
    end

    // Clear latch is held until an update event; set wins over the release
    always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
        cleared[c] <= 1'b0;
      end else if (clr_ok && etr_high) begin
        cleared[c] <= 1'b1;
      end else if (update_event) begin
        cleared[c] <= 1'b0;
      end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
        last_mode <= tpw_pkg::MODE_FROZEN;
        cmp_prev[c] <= 1'b0;
        ref_sig[c] <= 1'b0;
      end else begin
        last_mode <= mode;
        cmp_prev[c] <= cmp_res[c];
        if (clr_ok && etr_high) begin
          ref_sig[c] <= 1'b0;
        end else if (mode == tpw_pkg::MODE_FORCE_HIGH) begin
          ref_sig[c] <= 1'b1;
        end else if (mode == tpw_pkg::MODE_FORCE_LOW) begin
          ref_sig[c] <= 1'b0;
        end else if (pwm[c]) begin
          if (chan_cfg[c].fast_trigger_enable && ctrl.single_pulse_bit && ctrl.trigger_start
              && trig_edge) begin
            ref_sig[c] <= mode == tpw_pkg::MODE_PWM2;
          end else if (last_mode == tpw_pkg::MODE_FROZEN) begin
            ref_sig[c] <= cmp_res[c];
          end else if (cmp_res[c] != cmp_prev[c]) begin
            ref_sig[c] <= cmp_res[c] & ~cleared[c];
          end else if (cleared[c] && update_event && cmp_res[c]) begin
            ref_sig[c] <= 1'b1;
          end
        end else if (match[c]) begin
          // Compare modes ignore the update event entirely
          if (mode == tpw_pkg::MODE_SET) begin
            ref_sig[c] <= 1'b1;
          end else if (mode == tpw_pkg::MODE_CLEAR) begin
            ref_sig[c] <= 1'b0;
          end else if (mode == tpw_pkg::MODE_TOGGLE) begin
            ref_sig[c] <= ~ref_sig[c];
          end
        end
      end
    end

    // Output stage
    always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
        chan_out[c] <= 1'b0;
        compare_flag[c] <= 1'b0;
      end else begin
        chan_out[c] <= chan_cfg[c].output_enable_bit
                       & (ref_sig[c] ^ chan_cfg[c].output_polarity_bit);
        if (!center) begin
          compare_flag[c] <= match[c];
        end else if (ctrl.alignment_select_field == tpw_pkg::ALIGN_CENTER_DOWN) begin
          compare_flag[c] <= match[c] & ctrl.dir;
        end else if (ctrl.alignment_select_field == tpw_pkg::ALIGN_CENTER_UP) begin
          compare_flag[c] <= match[c] & ~ctrl.dir;
        end else begin
          compare_flag[c] <= match[c];
        end
      end
    end
  end

  // ==========================================================================
  // Read data
  // Captured in the setup cycle, so it stands through the whole access phase
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= '0;
      if (paddr == tpw_pkg::OFF_CTRL) begin
        prdata <= 32'(ctrl);
      end else if (paddr == tpw_pkg::OFF_CHCFG) begin
        prdata <= 32'(chan_cfg);
      end else if (paddr == tpw_pkg::OFF_PERIOD) begin
        prdata <= 32'(period_pre);
      end else if (paddr == tpw_pkg::OFF_COUNT) begin
        prdata <= 32'(count);
      end else if (paddr == tpw_pkg::OFF_STATUS) begin
        prdata <= 32'({cleared, ref_sig});
      end else begin
        for (int i = 0; i < NUM_CH; i++) begin
          if (is_cmp_addr(paddr, i)) begin
            prdata <= 32'(cmp_pre[i]);
          end
        end
      end
    end
  end

endmodule : tpw_channel_pwm

//--- testbench/tpw_channel_pwm_asserts.sv
// Purpose: Port-level checks for the timer channel waveform block
// Assumes: Channel 0 config is mirrored from APB writes only
// Notes: Of the hardware-updated fields only dir is mirrored, so checks use it with edge alignment only
`timescale 1ns/10ps
module tpw_channel_pwm_asserts #(
  parameter int CNT_W = 16,
  parameter int NUM_CH = 2
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic slave_trigger_input,
  input wire logic filtered_external_trigger,
  input wire logic [NUM_CH-1:0] chan_out,
  input wire logic [NUM_CH-1:0] compare_flag
);
  // ====================
  // Config mirror
  logic [7:0] cfg;
  logic [2:0] ctl;
  logic [CNT_W-1:0] per;
  logic cz;
  wire [2:0] m = cfg[2:0];
  wire oe = cfg[tpw_pkg::CH_OE];
  wire pol = cfg[tpw_pkg::CH_POL];
  wire clr = cfg[tpw_pkg::CH_CLR];
  wire fast = cfg[tpw_pkg::CH_FAST];
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg <= 8'h00;
      ctl <= 3'h0;
      per <= {CNT_W{1'b1}};
      cz <= 1'b1;
    end else if (psel && penable && pwrite) begin
      if (paddr == tpw_pkg::OFF_CHCFG) cfg <= pwdata[7:0];
      if (paddr == tpw_pkg::OFF_CTRL) ctl <= pwdata[4:2];
      if (paddr == tpw_pkg::OFF_PERIOD) per <= pwdata[CNT_W-1:0];
      // Only a direct-load zero is trusted; a preloaded one may still be pending
      if (paddr == tpw_pkg::OFF_CMP0) cz <= (pwdata[CNT_W-1:0] == '0) && !cfg[tpw_pkg::CH_PRE];
    end
  end
  // ====================
  // Properties
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  ready_high_a: assert property (pready) else $error("pready low");
  err_unmapped_a: assert property (psel && penable && paddr > 8'h1f |-> pslverr)
    else $error("no error on unmapped access");
  err_idle_a: assert property (!(psel && penable) |-> !pslverr) else $error("stray error");
  period_read_a: assert property (
    psel && penable && !pwrite && paddr == tpw_pkg::OFF_PERIOD |-> prdata[CNT_W-1:0] == per)
    else $error("period readback wrong");
  out_off_a: assert property (!oe [*3] |-> chan_out[0] == 1'b0)
    else $error("output driven while disabled");
  // Config must have settled: the output stage lags a polarity change by a cycle
  force_high_a: assert property (
    (m == tpw_pkg::MODE_FORCE_HIGH && oe && $stable(cfg)) [*4] |-> chan_out[0] == !pol)
    else $error("forced high level wrong");
  force_low_a: assert property (
    (m == tpw_pkg::MODE_FORCE_LOW && oe && $stable(cfg)) [*4] |-> chan_out[0] == pol)
    else $error("forced low level wrong");
  ext_clear_a: assert property (
    (clr && oe && !pol && m != tpw_pkg::MODE_FORCE_HIGH && filtered_external_trigger) [*6]
    |-> !chan_out[0]) else $error("reference not cleared");
  zero_cmp_a: assert property (
    (m == tpw_pkg::MODE_PWM1 && oe && !pol && !fast && cz && ctl == 3'h0) [*4]
    |-> !chan_out[0]) else $error("zero compare not low");
  cover property (filtered_external_trigger && clr && !chan_out[0]);
  cover property (psel && penable && pslverr);
  cover property ($rose(chan_out[0]));
  cover property (compare_flag[0]);
endmodule : tpw_channel_pwm_asserts

//--- testbench/tpw_far_model.sv
// Purpose: Trigger source and waveform load on the channel pins
// Assumes: Called from the bench just after a rising clock edge
// Notes: Measures high time, rise count and delay from the last trigger
`timescale 1ns/10ps
module tpw_far_model (
  input wire logic ref_clk,
  input wire logic chan_level,
  output logic trig_pin,
  output logic clear_pin
);
  int t = 0, start = 0, rise_t = 0, hi_len = 0, delay = 0, n_rise = 0;
  logic last = 1'b0;
  initial begin
    trig_pin = 1'b0;
    clear_pin = 1'b0;
  end
  always @(posedge ref_clk) begin
    t <= t + 1;
    last <= chan_level;
    if (chan_level && !last) begin
      rise_t <= t;
      delay <= t - start;
      n_rise <= n_rise + 1;
    end
    if (!chan_level && last) hi_len <= t - rise_t;
  end
  // Clean edge held several ticks so the synchroniser cannot miss it
  task pulse_trigger;
    start <= t;
    trig_pin <= 1'b1;
    repeat (4) @(posedge ref_clk);
    trig_pin <= 1'b0;
  endtask : pulse_trigger
  // Plain level, no prescaler or clock mode in front of it
  task set_clear(input logic lvl);
    clear_pin <= lvl;
  endtask : set_clear
endmodule : tpw_far_model

//--- testbench/tb.sv
// Purpose: Self-checking bench for the timer channel waveform block
// Assumes: Single clock at 250 MHz, APB master driven on rising edges
// Notes: Waveform timing is measured by the far-side model on channel 0
`timescale 1ns/10ps
module tb;
  localparam logic [31:0] EN = 32'h1 << tpw_pkg::CTRL_EN;
  localparam logic [31:0] SP = 32'h1 << tpw_pkg::CTRL_SINGLE;
  localparam logic [31:0] DIR = 32'h1 << tpw_pkg::CTRL_DIR;
  localparam logic [31:0] PP = 32'h1 << tpw_pkg::CTRL_PPRE;
  localparam logic [31:0] TS = 32'h1 << tpw_pkg::CTRL_TRIG_START;
  localparam logic [31:0] CA = 32'h1 << tpw_pkg::CTRL_ALIGN_LO;
  logic ref_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h2d;
  logic pready, pslverr, er, trig, clr;
  logic [1:0] chan_out, cflag;
  int mismatches = 0, tests_run = 0, cyc = 0;
  logic [2:0] fm [4] = '{tpw_pkg::MODE_FORCE_HIGH, tpw_pkg::MODE_FORCE_HIGH,
    tpw_pkg::MODE_FORCE_LOW, tpw_pkg::MODE_FORCE_HIGH};
  logic [4:0] fb [4] = '{5'h14, 5'h1c, 5'h14, 5'h04};
  logic fe [4] = '{1'b1, 1'b0, 1'b0, 1'b0};
  always #2 ref_clk = ~ref_clk;
  tpw_channel_pwm DUT (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .slave_trigger_input(trig), .filtered_external_trigger(clr),
    .chan_out(chan_out), .compare_flag(cflag));
  tpw_far_model far (.ref_clk(ref_clk), .chan_level(chan_out[0]), .trig_pin(trig),
    .clear_pin(clr));
  // ====================
  // Helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [31:0] chw(input logic [2:0] m, input logic [4:0] b);
    return {24'h0, b, m};
  endfunction : chw
  function automatic int exp_hi(input logic m2, input logic dn, input int p, input int c);
    int h;
    h = dn ? c + 1 : c;
    return m2 ? p + 1 - h : h;
  endfunction : exp_hi
  // An idle cycle follows each transfer, so psel never changes twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  task automatic check(input string n, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, exp, got);
    end
  endtask : check
  // Stop, load, force an update, then start: keeps the start state defined
  task automatic setup(input logic [31:0] ctl, input logic [31:0] ch, input int p, input int c);
    apb(1'b1, tpw_pkg::OFF_CTRL, ctl & ~EN);
    apb(1'b1, tpw_pkg::OFF_CHCFG, ch);
    apb(1'b1, tpw_pkg::OFF_PERIOD, p);
    apb(1'b1, tpw_pkg::OFF_CMP0, c);
    apb(1'b1, tpw_pkg::OFF_EVENT, 32'h1);
    apb(1'b1, tpw_pkg::OFF_CTRL, ctl);
  endtask : setup
  task finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      finish_test;
    end
  end
  // ====================
  // Sequence
  initial begin
    int p;
    int c;
    int n;
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    apb(1'b1, tpw_pkg::OFF_PERIOD, 32'h1234);
    apb(1'b0, tpw_pkg::OFF_PERIOD, 32'h0);
    check("period readback", rd, 32'h1234);
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped error", er, 1'b1);
    check("unmapped data", rd, 32'h0);
    $display("registers done");
    for (int i = 0; i < 3; i++) begin
      p = 10 + rnd() % 30;
      c = 1 + rnd() % (p - 1);
      for (int k = 0; k < 4; k++) begin
        setup(EN | PP | (k[0] ? DIR : 32'h0),
          chw(k[1] ? tpw_pkg::MODE_PWM2 : tpw_pkg::MODE_PWM1, 5'h11), p, c);
        repeat (3 * p + 12) @(posedge ref_clk);
        check("high length", far.hi_len, exp_hi(k[1], k[0], p, c));
      end
    end
    setup(EN | PP, chw(tpw_pkg::MODE_PWM1, 5'h10), 20, 0);
    repeat (40) @(posedge ref_clk);
    check("zero compare", chan_out[0], 1'b0);
    $display("pwm done");
    setup(EN | PP, chw(tpw_pkg::MODE_PWM1, 5'h15), 40, 50);
    repeat (90) @(posedge ref_clk);
    check("full duty", chan_out[0], 1'b1);
    far.set_clear(1'b1);
    repeat (8) @(posedge ref_clk);
    check("cleared", chan_out[0], 1'b0);
    far.set_clear(1'b0);
    n = 0;
    while (chan_out[0] !== 1'b1 && n < 60) begin
      @(posedge ref_clk);
      n++;
    end
    check("restored", n < 60, 1'b1);
    far.set_clear(1'b1);
    for (int j = 0; j < 4; j++) begin
      apb(1'b1, tpw_pkg::OFF_CHCFG, chw(fm[j], fb[j]));
      repeat (8) @(posedge ref_clk);
      check("forced level", chan_out[0], fe[j]);
    end
    far.set_clear(1'b0);
    $display("clear done");
    // Counter left at zero, below the compare value, before the trigger
    setup(SP | TS | PP, chw(tpw_pkg::MODE_PWM2, 5'h11), 30, 10);
    n = far.n_rise;
    far.pulse_trigger();
    repeat (80) @(posedge ref_clk);
    check("one pulse", far.n_rise - n, 1);
    // High from the compare value up to the period value, both counted
    check("pulse length", far.hi_len, 30 - 10 + 1);
    check("pulse delay", far.delay >= 10, 1'b1);
    apb(1'b0, tpw_pkg::OFF_CTRL, 32'h0);
    check("stopped", rd[tpw_pkg::CTRL_EN], 1'b0);
    apb(1'b1, tpw_pkg::OFF_CHCFG, chw(tpw_pkg::MODE_PWM2, 5'h13));
    apb(1'b1, tpw_pkg::OFF_EVENT, 32'h1);
    far.pulse_trigger();
    repeat (80) @(posedge ref_clk);
    check("fast start", far.delay < 10, 1'b1);
    $display("single pulse done");
    // Center mode flags on the down count only: one flag per up-down sweep
    setup(EN | PP | CA, chw(tpw_pkg::MODE_PWM1, 5'h11), 20, 8);
    n = 0;
    repeat (160) begin
      @(posedge ref_clk);
      n += cflag[0];
    end
    check("center flags", n, 160 / (2 * 20));
    check("center high", far.hi_len, 2 * 8);
    $display("center done");
    finish_test;
  end
endmodule : tb
bind tpw_channel_pwm tpw_channel_pwm_asserts #(.CNT_W(CNT_W), .NUM_CH(NUM_CH)) chk (
  .ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .slave_trigger_input(slave_trigger_input),
  .filtered_external_trigger(filtered_external_trigger),
  .chan_out(chan_out), .compare_flag(compare_flag));
